//--- rtl/spfac_pkg.sv
// Shared constants for the single-precision arithmetic and conversion datapath.
// Assumes the instruction decoder presents one decoded operation at a time.
package spfac_pkg;

  // Decoded operations accepted on the request port.
  typedef enum logic [3:0] {
    FP_ABSOLUTE_OP         = 4'h0,
    FP_ADD_OP              = 4'h1,
    FP_COMPARE_OP          = 4'h2,
    FP_COMPARE_NAN_TRAP_OP = 4'h3,
    FP_CONVERT_OP_F2I      = 4'h4,
    FP_CONVERT_ROUNDED_OP  = 4'h5,
    FP_CONVERT_OP_I2F      = 4'h6,
    FP_CONVERT_OP_F2X      = 4'h7,
    FP_CONVERT_OP_X2F      = 4'h8,
    FP_DIVIDE_OP           = 4'h9
  } spfac_op_e;

  // Sequencer states; only the divide leaves the idle state.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_PACK = 2'b10
  } spfac_state_e;

  // Rounding mode encodings of the status and control register field.
  localparam logic [1:0]  RM_NEAREST = 2'h0;
  localparam logic [1:0]  RM_PLUS    = 2'h1;
  localparam logic [1:0]  RM_MINUS   = 2'h2;
  localparam logic [1:0]  RM_ZERO    = 2'h3;

  // Compare outcomes as N Z C V.
  localparam logic [3:0]  FLG_LT     = 4'h8;
  localparam logic [3:0]  FLG_EQ     = 4'h6;
  localparam logic [3:0]  FLG_GT     = 4'h2;
  localparam logic [3:0]  FLG_UN     = 4'h3;
  localparam logic [3:0]  FLG_RST    = 4'h0;

  localparam logic [31:0] DEFAULT_NAN = 32'h7fc00000;
  localparam logic [5:0]  FB16_MAX    = 6'h10;
  localparam logic [5:0]  FB32_MIN    = 6'h01;
  localparam logic [5:0]  FB32_MAX    = 6'h20;
  // Quotient bits produced one per cycle, then one cycle to round.
  localparam logic [4:0]  DIV_STEPS   = 5'h1b;

endpackage

//--- rtl/spfac_core.sv
// Single-precision absolute, add, divide, compare and conversion datapath.
// Assumes the core decodes, reads operands, and writes back on res_write.
// Behaviour
// - Absolute value writes the operand magnitude to the destination.
// - Absolute value and add leave all condition flags untouched.
// - Add sums both operands and writes the rounded sum.
// - Compare two operands or one against plus zero into status flags.
// - Trapping compare faults on any NaN; plain compare only on signaling NaN.
// - Core flags change only when the status flags are moved over.
// - Float to 32-bit integer truncates, or uses status mode when rounded.
// - Integer to float rounds with the status register mode.
// - Fixed point types signed and unsigned 16 and 32 bit, one register.
// - Fraction bits 0 to 16 for 16-bit, 1 to 32 for 32-bit types.
// - From 16-bit fixed point only the low half of the source counts.
// - Signed fixed point results sign-extend to the full register.
// - Unsigned fixed point results zero-extend to the full register.
// - Float to fixed point always truncates toward zero.
// - Fixed point to float always rounds to nearest.
// - Divide writes first operand over second operand to the destination.
`timescale 1ns/100ps
`default_nettype none
module spfac_core (
  input  wire  logic                  ref_clk,
  input  wire  logic                  rst,
  input  wire  logic                  op_valid,
  output logic                        op_ready,
  input  wire  spfac_pkg::spfac_op_e  op_code,
  input  wire  logic [31:0]           first_src,
  input  wire  logic [31:0]           second_src,
  input  wire  logic                  cmp_with_zero,
  input  wire  logic                  cvt_unsigned,
  input  wire  logic                  fix_16,
  input  wire  logic [5:0]            fbits,
  input  wire  logic [1:0]            fp_rmode,
  input  wire  logic                  fp_status_xfer,
  input  wire  logic                  ioc_clear,
  output logic                        res_valid,
  output logic                        res_write,
  output logic [31:0]                 res_data,
  output logic                        op_rejected,
  output logic                        invalid_op,
  output logic                        ioc_sticky,
  output logic [3:0]                  fp_status_flags,
  output logic [3:0]                  core_flags
);
  import spfac_pkg::*;

  function automatic logic f_nan(input logic [31:0] f);
    return (f[30:23] == 8'hff) && (f[22:0] != 23'h0);
  endfunction

  function automatic logic f_snan(input logic [31:0] f);
    return f_nan(f) && !f[22];
  endfunction

  function automatic logic f_inf(input logic [31:0] f);
    return (f[30:0] == {8'hff, 23'h0});
  endfunction

  // Subnormals are flushed, so a zero exponent means zero.
  function automatic logic f_zero(input logic [31:0] f);
    return (f[30:23] == 8'h00);
  endfunction

  function automatic logic rnd_up(input logic s, input logic l, input logic g,
                                  input logic st, input logic [1:0] rm);
    logic r;
    r = 1'b0;
    case (rm)
      RM_NEAREST: r = g & (st | l);
      RM_PLUS:    r = !s & (g | st);
      RM_MINUS:   r = s & (g | st);
      default:    r = 1'b0;
    endcase
    return r;
  endfunction

  // Normalise and round m * 2^(e-176); bit 0 of m may carry a sticky.
  function automatic logic [31:0] fp_pack(input logic s, input logic signed [11:0] e,
                                          input logic [49:0] m, input logic [1:0] rm);
    logic [49:0]        n;
    logic signed [11:0] x;
    logic [24:0]        r;
    n = m;
    x = e;
    for (int i = 0; i < 50; i++) begin
      if (!n[49] && (n != 50'h0)) begin
        n = n << 1;
        x = x - 12'sd1;
      end
    end
    r = {1'b0, n[49:26]} + {24'h0, rnd_up(s, n[26], n[25], |n[24:0], rm)};
    if (r[24]) begin
      x = x + 12'sd1;
      r = r >> 1;
    end
    if ((m == 50'h0) || (x <= 12'sd0)) return {s, 31'h0};
    if (x >= 12'sd255) return {s, 8'hff, 23'h0};
    return {s, x[7:0], r[22:0]};
  endfunction

  // Returns {invalid, sum}.
  function automatic logic [32:0] fp_add(input logic [31:0] a, input logic [31:0] b,
                                         input logic [1:0] rm);
    logic [31:0] x;
    logic [31:0] y;
    logic [49:0] mx;
    logic [49:0] my;
    logic [49:0] sm;
    logic [7:0]  d;
    logic [7:0]  sh;
    if (f_nan(a) || f_nan(b)) return {f_snan(a) | f_snan(b), DEFAULT_NAN};
    if (f_inf(a) && f_inf(b) && (a[31] != b[31])) return {1'b1, DEFAULT_NAN};
    if (f_inf(a)) return {1'b0, a};
    if (f_inf(b)) return {1'b0, b};
    x = (a[30:0] < b[30:0]) ? b : a;
    y = (a[30:0] < b[30:0]) ? a : b;
    // Subnormals flush to zero here as in every operation except absolute value.
    mx = f_zero(x) ? 50'h0 : {2'b01, x[22:0], 25'h0};
    my = f_zero(y) ? 50'h0 : {2'b01, y[22:0], 25'h0};
    d = x[30:23] - y[30:23];
    sh = (d > 8'd49) ? 8'd49 : d;
    // Bits shifted out survive as a sticky so rounding stays exact.
    my = (my >> sh) | {49'h0, |(my & ((50'h1 << sh) - 50'h1))};
    sm = (x[31] == y[31]) ? (mx + my) : (mx - my);
    if (sm == 50'h0) return {1'b0, a[31] & b[31], 31'h0};
    return {1'b0, fp_pack(x[31], $signed({4'h0, x[30:23]}) + 12'sd1, sm, rm)};
  endfunction

  // Returns {invalid, NZCV}.
  function automatic logic [4:0] fp_cmp(input logic [31:0] a, input logic [31:0] b,
                                        input logic trap);
    logic signed [32:0] ka;
    logic signed [32:0] kb;
    logic               un;
    un = f_nan(a) | f_nan(b);
    ka = f_zero(a) ? 33'sd0 : (a[31] ? -$signed({2'b0, a[30:0]}) : $signed({2'b0, a[30:0]}));
    kb = f_zero(b) ? 33'sd0 : (b[31] ? -$signed({2'b0, b[30:0]}) : $signed({2'b0, b[30:0]}));
    if (un) return {f_snan(a) | f_snan(b) | trap, FLG_UN};
    if (ka == kb) return {1'b0, FLG_EQ};
    return {1'b0, (ka < kb) ? FLG_LT : FLG_GT};
  endfunction

  // Float to integer or fixed point with saturation; returns {invalid, value}.
  function automatic logic [32:0] fp_f2i(input logic [31:0] a, input logic [1:0] rm,
                                         input logic us, input logic w16,
                                         input logic [5:0] fb);
    logic signed [11:0] d;
    logic [127:0]       w;
    logic [32:0]        mg;
    logic [32:0]        mp;
    logic [32:0]        mn;
    logic               s;
    s = a[31];
    mp = w16 ? (us ? 33'h0ffff : 33'h07fff) : (us ? 33'h0ffffffff : 33'h07fffffff);
    mn = us ? 33'h0 : (w16 ? 33'h08000 : 33'h080000000);
    if (f_nan(a)) return {1'b1, 32'h0};
    if (f_zero(a)) return {1'b0, 32'h0};
    d = 12'sd190 - $signed({4'h0, a[30:23]}) - $signed({6'h0, fb});
    w = {1'b1, a[22:0], 104'h0} >> ((d > 12'sd127) ? 7'd127 : d[6:0]);
    mg = {1'b0, w[95:64]} + {32'h0, rnd_up(s, w[64], w[63], |w[62:0], rm)};
    if (f_inf(a) || (d < 12'sd32) || (s ? (mg > mn) : (mg > mp))) begin
      return {1'b1, s ? (32'h0 - mn[31:0]) : mp[31:0]};
    end
    return {1'b0, s ? (32'h0 - mg[31:0]) : mg[31:0]};
  endfunction

  function automatic logic [31:0] fp_i2f(input logic [31:0] v0, input logic us,
                                         input logic w16, input logic [5:0] fb,
                                         input logic [1:0] rm);
    logic [31:0] v;
    logic [31:0] mg;
    logic        s;
    v = w16 ? (us ? {16'h0, v0[15:0]} : {{16{v0[15]}}, v0[15:0]}) : v0;
    s = !us & v[31];
    mg = s ? (32'h0 - v) : v;
    return fp_pack(s, 12'sd158 - $signed({6'h0, fb}), {mg, 18'h0}, rm);
  endfunction

  spfac_state_e state_q;
  spfac_state_e state_d;
  logic [26:0]  quo_q;
  logic [25:0]  rem_q;
  logic [23:0]  dvs_q;
  logic [4:0]   cnt_q;
  logic         dsgn_q;
  logic [11:0]  dexp_q;
  logic         res_valid_q;
  logic         res_write_q;
  logic [31:0]  res_data_q;
  logic         rej_q;
  logic         inv_q;
  logic         ioc_q;
  logic [3:0]   fpf_q;
  logic [3:0]   cf_q;

  // Operation decode; conversions share one converter in each direction.
  wire         accept  = op_valid && op_ready;
  wire         is_cmp  = (op_code == FP_COMPARE_OP) || (op_code == FP_COMPARE_NAN_TRAP_OP);
  wire         is_f2x  = (op_code == FP_CONVERT_OP_F2X);
  wire         is_x2f  = (op_code == FP_CONVERT_OP_X2F);
  wire         is_fix  = is_f2x || is_x2f;
  wire         is_div  = (op_code == FP_DIVIDE_OP);
  wire         fb_ok   = fix_16 ? (fbits <= FB16_MAX) :
                         ((fbits >= FB32_MIN) && (fbits <= FB32_MAX));
  wire         reject  = is_fix && !fb_ok;
  wire [5:0]   cv_fb   = is_fix ? fbits : 6'h0;
  wire         cv_w16  = is_fix && fix_16;
  wire [1:0]   f2i_rm  = (op_code == FP_CONVERT_ROUNDED_OP) ? fp_rmode : RM_ZERO;
  wire [1:0]   i2f_rm  = is_x2f ? RM_NEAREST : fp_rmode;
  wire [31:0]  cmp_b   = cmp_with_zero ? 32'h0 : second_src;
  wire [32:0]  add_r   = fp_add(first_src, second_src, fp_rmode);
  wire [4:0]   cmp_r   = fp_cmp(first_src, cmp_b, op_code == FP_COMPARE_NAN_TRAP_OP);
  wire [32:0]  f2i_r   = fp_f2i(second_src, f2i_rm, cvt_unsigned, cv_w16, cv_fb);
  wire [31:0]  i2f_r   = fp_i2f(second_src, cvt_unsigned, cv_w16, cv_fb, i2f_rm);

  // Divide operands that need no iteration are answered at once.
  wire         n_a     = f_nan(first_src);
  wire         n_b     = f_nan(second_src);
  wire         dv_sgn  = first_src[31] ^ second_src[31];
  wire         dv_bad  = (f_inf(first_src) && f_inf(second_src)) ||
                         (f_zero(first_src) && f_zero(second_src));
  wire         dv_inf  = f_inf(first_src) || f_zero(second_src);
  wire         dv_zro  = f_zero(first_src) || f_inf(second_src);
  wire         dv_spec = n_a || n_b || dv_bad || dv_inf || dv_zro;
  wire [32:0]  dv_r    = (n_a || n_b) ? {f_snan(first_src) | f_snan(second_src), DEFAULT_NAN} :
                         dv_bad ? {1'b1, DEFAULT_NAN} :
                         dv_inf ? {1'b0, dv_sgn, 8'hff, 23'h0} : {1'b0, dv_sgn, 31'h0};
  wire         div_go  = accept && is_div && !dv_spec;

  // Result and invalid indication of a single-cycle operation.
  wire [32:0]  one_r   = (op_code == FP_ABSOLUTE_OP) ? {1'b0, 1'b0, second_src[30:0]} :
                         (op_code == FP_ADD_OP) ? add_r :
                         is_cmp ? {cmp_r[4], res_data_q} :
                         (is_x2f || (op_code == FP_CONVERT_OP_I2F)) ? {1'b0, i2f_r} :
                         is_div ? dv_r : f2i_r;

  // Restoring divider step and the final rounding of the quotient.
  wire         dv_ge   = rem_q >= {2'b0, dvs_q};
  wire [25:0]  dv_rem  = dv_ge ? (rem_q - {2'b0, dvs_q}) : rem_q;
  wire [31:0]  dv_out  = fp_pack(dsgn_q, $signed(dexp_q),
                                 {1'b0, quo_q, 21'h0, rem_q != 26'h0}, fp_rmode);

  assign op_ready = (state_q == ST_IDLE);

  // Only the divide occupies the datapath for more than one cycle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (div_go) state_d = ST_DIV;
      ST_DIV:  if (cnt_q == 5'h0) state_d = ST_PACK;
      ST_PACK: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Divider registers; the quotient collects one bit per cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      quo_q  <= 27'h0;
      rem_q  <= 26'h0;
      dvs_q  <= 24'h0;
      cnt_q  <= 5'h0;
      dsgn_q <= 1'b0;
      dexp_q <= 12'h0;
    end else if (div_go) begin
      rem_q  <= {3'b001, first_src[22:0]};
      dvs_q  <= {1'b1, second_src[22:0]};
      cnt_q  <= DIV_STEPS - 5'h1;
      dsgn_q <= dv_sgn;
      dexp_q <= {4'h0, first_src[30:23]} - {4'h0, second_src[30:23]} + 12'd128;
    end else if (state_q == ST_DIV) begin
      quo_q <= {quo_q[25:0], dv_ge};
      rem_q <= (cnt_q == 5'h0) ? dv_rem : {dv_rem[24:0], 1'b0};
      cnt_q <= cnt_q - 5'h1;
    end
  end

  // Result port, status flags and the sticky invalid indication.
  wire         one_go  = accept && !reject && !div_go;
  wire         pack_go = (state_q == ST_PACK);
  wire         inv_set = one_go && one_r[32];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      res_valid_q <= 1'b0;
      res_write_q <= 1'b0;
      res_data_q  <= 32'h0;
      rej_q       <= 1'b0;
      inv_q       <= 1'b0;
      ioc_q       <= 1'b0;
      fpf_q       <= FLG_RST;
      cf_q        <= FLG_RST;
    end else begin
      state_q     <= state_d;
      res_valid_q <= one_go || pack_go;
      res_write_q <= (one_go && !is_cmp) || pack_go;
      if (pack_go) res_data_q <= dv_out;
      else if (one_go && !is_cmp) res_data_q <= one_r[31:0];
      rej_q       <= accept && reject;
      inv_q       <= inv_set;
      ioc_q       <= (ioc_q && !ioc_clear) || inv_set;
      if (one_go && is_cmp) fpf_q <= cmp_r[3:0];
      if (fp_status_xfer) cf_q <= fpf_q;
    end
  end

  assign res_valid       = res_valid_q;
  assign res_write       = res_write_q;
  assign res_data        = res_data_q;
  assign op_rejected     = rej_q;
  assign invalid_op      = inv_q;
  assign ioc_sticky      = ioc_q;
  assign fp_status_flags = fpf_q;
  assign core_flags      = cf_q;

  // Checks on accepted operations and their answers, the flag registers and the sticky.
  AST_ABS_MAG: assert property (@(posedge ref_clk) disable iff (rst)
    accept && op_code == FP_ABSOLUTE_OP |=> res_write && res_data == {1'b0, $past(second_src[30:0])})
    else $error("absolute value result wrong");
  AST_CORE_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !fp_status_xfer |=> $stable(core_flags)) else $error("core flags moved without transfer");
  AST_ADD_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    accept && op_code == FP_ADD_OP && second_src == 32'h0 && !f_zero(first_src) &&
    first_src[30:23] != 8'hff |=> res_data == $past(first_src)) else $error("add of zero wrong");
  AST_CMP_EQ: assert property (@(posedge ref_clk) disable iff (rst)
    accept && is_cmp && !cmp_with_zero && first_src == second_src && !n_a
    |=> fp_status_flags == FLG_EQ && !res_write) else $error("equal compare flags wrong");
  AST_SNAN_INV: assert property (@(posedge ref_clk) disable iff (rst)
    accept && is_cmp && (f_snan(first_src) || (!cmp_with_zero && f_snan(second_src)))
    |=> invalid_op ##1 ioc_sticky || ioc_clear) else $error("signaling NaN not trapped");
  AST_QNAN_PLAIN: assert property (@(posedge ref_clk) disable iff (rst)
    accept && op_code == FP_COMPARE_OP && cmp_with_zero && n_a && !f_snan(first_src)
    |=> !invalid_op && fp_status_flags == FLG_UN) else $error("quiet NaN trapped");
  AST_XFER: assert property (@(posedge ref_clk) disable iff (rst)
    fp_status_xfer |=> core_flags == $past(fp_status_flags)) else $error("flag transfer lost");
  AST_F2I_RND: assert property (@(posedge ref_clk) disable iff (rst)
    accept && second_src == 32'h3fc00000 && !cvt_unsigned && (op_code == FP_CONVERT_OP_F2I ||
    (op_code == FP_CONVERT_ROUNDED_OP && fp_rmode == RM_NEAREST))
    |=> res_data == ($past(op_code) == FP_CONVERT_OP_F2I ? 32'h1 : 32'h2))
    else $error("float to integer rounding wrong");
  AST_FB_REJ: assert property (@(posedge ref_clk) disable iff (rst)
    accept && reject |=> op_rejected && !res_valid) else $error("illegal fraction bits taken");
  AST_DIV_LAT: assert property (@(posedge ref_clk) disable iff (rst)
    div_go |=> !op_ready [*8] ##20 !res_valid ##1 res_valid && res_write)
    else $error("divide answer not on time");
  AST_IOC: assert property (@(posedge ref_clk) disable iff (rst)
    invalid_op |-> ioc_sticky) else $error("invalid not recorded");

endmodule
`default_nettype wire

//--- sim/spfac_core_model.sv
// Core-side model: decode and register file that issue one operation at a time.
// Assumes the datapath answers within sixty cycles of taking a request.
`timescale 1ns/100ps
`default_nettype none
module spfac_core_model (
  input  wire logic                  ref_clk,
  input  wire logic                  op_ready,
  input  wire logic                  res_valid,
  input  wire logic                  res_write,
  input  wire logic [31:0]           res_data,
  input  wire logic                  op_rejected,
  input  wire logic                  invalid_op,
  output logic                       op_valid,
  output var spfac_pkg::spfac_op_e   op_code,
  output logic [31:0]                first_src,
  output logic [31:0]                second_src,
  output logic                       cmp_with_zero,
  output logic                       cvt_unsigned,
  output logic                       fix_16,
  output logic [5:0]                 fbits,
  output logic [1:0]                 fp_rmode,
  output logic                       fp_status_xfer,
  output logic                       ioc_clear
);
  import spfac_pkg::*;

  logic [31:0] wr_q;
  logic        got_v;
  logic        got_w;
  logic        got_r;
  logic        got_i;
  int          lat;
  int          busy;

  // Every request line starts idle so nothing floats before reset ends.
  initial begin
    {op_valid, first_src, second_src, fbits, wr_q} = '0;
    {cmp_with_zero, cvt_unsigned, fix_16, fp_rmode} = '0;
    {fp_status_xfer, ioc_clear} = '0;
    op_code = FP_ABSOLUTE_OP;
  end

  // Holds the request until taken, then scrambles the released operands.
  // The mode field packs rounding mode, 16-bit type, unsigned and zero compare.
  task automatic run(input spfac_op_e op, input logic [31:0] a, input logic [31:0] b,
                     input logic [5:0] fb, input logic [4:0] md);
    @(negedge ref_clk);
    op_valid   = 1'b1;
    op_code    = op;
    first_src  = a;
    second_src = b;
    fbits      = fb;
    {fp_rmode, fix_16, cvt_unsigned, cmp_with_zero} = md;
    while (op_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    op_valid   = 1'b0;
    first_src  = ~a;
    second_src = ~b;
    lat        = 1;
    busy       = (op_ready !== 1'b1);
    while (res_valid !== 1'b1 && op_rejected !== 1'b1 && lat < 60) begin
      @(negedge ref_clk);
      lat = lat + 1;
      if (op_ready !== 1'b1) busy = busy + 1;
    end
    {got_v, got_w, got_r, got_i} = {res_valid, res_write, op_rejected, invalid_op};
    if (res_write === 1'b1) wr_q = res_data;
  endtask

  // One-cycle pulse of either the flag move or the sticky clear.
  task automatic pulse(input logic clr);
    @(negedge ref_clk);
    fp_status_xfer = ~clr;
    ioc_clear      = clr;
    @(negedge ref_clk);
    fp_status_xfer = 1'b0;
    ioc_clear      = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/single_precision_fp_arith_convert_tb.sv
// Self-checking bench for the single-precision arithmetic and conversion datapath.
// Assumes the core-side model issues each request and captures the write-back.
`timescale 1ns/100ps
`default_nettype none
module single_precision_fp_arith_convert_tb;
  import spfac_pkg::*;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid, op_ready, cmp_with_zero, cvt_unsigned, fix_16;
  spfac_op_e   op_code;
  logic [31:0] first_src, second_src, res_data;
  logic [5:0]  fbits;
  logic [1:0]  fp_rmode;
  logic        fp_status_xfer, ioc_clear, res_valid, res_write;
  logic        op_rejected, invalid_op, ioc_sticky;
  logic [3:0]  fp_status_flags, core_flags;
  int          error_cnt = 0;
  int          tests_run = 0;

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  spfac_core u_dut (.ref_clk, .rst, .op_valid, .op_ready, .op_code, .first_src,
    .second_src, .cmp_with_zero, .cvt_unsigned, .fix_16, .fbits, .fp_rmode,
    .fp_status_xfer, .ioc_clear, .res_valid, .res_write, .res_data, .op_rejected,
    .invalid_op, .ioc_sticky, .fp_status_flags, .core_flags);

  spfac_core_model u_core (.ref_clk, .op_ready, .res_valid, .res_write, .res_data,
    .op_rejected, .invalid_op, .op_valid, .op_code, .first_src, .second_src,
    .cmp_with_zero, .cvt_unsigned, .fix_16, .fbits, .fp_rmode, .fp_status_xfer,
    .ioc_clear);

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Register and zero compares, quiet and signaling NaNs, sticky and flag move.
  task automatic t_cmp;
    logic [31:0] a [8] = '{32'h3f800000, 32'h3f800000, 32'h40000000, 32'hbf800000,
                           32'h80000000, 32'h7fc00000, 32'h7fc00000, 32'h3f800000};
    logic [31:0] b [8] = '{32'h3f800000, 32'h40000000, 32'h3f800000, 32'hc0000000,
                           32'h3f800000, 32'h3f800000, 32'h3f800000, 32'h7f800001};
    logic [3:0]  f [8] = '{FLG_EQ, FLG_LT, FLG_GT, FLG_LT, FLG_EQ, FLG_UN, FLG_UN, FLG_UN};
    logic [7:0]  z     = 8'b00111000;
    logic [7:0]  t     = 8'b01000000;
    logic [7:0]  v     = 8'b11000000;
    chk("core flags idle", {28'h0, core_flags}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      u_core.run(t[i] ? FP_COMPARE_NAN_TRAP_OP : FP_COMPARE_OP, a[i], b[i], 6'h0,
                 {4'h0, z[i]});
      chk("cmp flags", {28'h0, fp_status_flags}, {28'h0, f[i]});
      chk("cmp no write", {30'h0, u_core.got_v, u_core.got_w}, 32'h2);
      chk("cmp invalid", {31'h0, u_core.got_i}, {31'h0, v[i]});
      chk("ioc sticky", {31'h0, ioc_sticky}, {31'h0, v[i]});
      if (v[i]) u_core.pulse(1'b1);
    end
    chk("ioc cleared", {31'h0, ioc_sticky}, 32'h0);
    chk("core flags held", {28'h0, core_flags}, 32'h0);
    u_core.pulse(1'b0);
    chk("core flags moved", {28'h0, core_flags}, {28'h0, FLG_UN});
    $display("compare test done");
  endtask

  // Magnitude, sums with cancellation, a rounding tie and a zero; flags must not move.
  task automatic t_arith;
    logic [31:0] a [6] = '{32'h3f800000, 32'h3f800000, 32'h3fc00000, 32'h3f800000,
                           32'h3f800000, 32'h40490fdb};
    logic [31:0] b [6] = '{32'hc0490fdb, 32'h40000000, 32'hbfc00000, 32'h33800000,
                           32'h33800000, 32'h00000000};
    logic [31:0] e [6] = '{32'h40490fdb, 32'h40400000, 32'h00000000, 32'h3f800000,
                           32'h3f800001, 32'h40490fdb};
    logic [4:0]  m [6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h08, 5'h00};
    for (int i = 0; i < 6; i++) begin
      u_core.run(i == 0 ? FP_ABSOLUTE_OP : FP_ADD_OP, a[i], b[i], 6'h0, m[i]);
      chk("arith data", res_data, e[i]);
      chk("arith write", {31'h0, u_core.got_w}, 32'h1);
      chk("arith flags", {24'h0, fp_status_flags, core_flags}, 32'h33);
    end
    $display("arith test done");
  endtask

  // Float and 32-bit integer conversions in every relevant rounding mode.
  task automatic t_int;
    spfac_op_e   o [10] = '{FP_CONVERT_OP_F2I, FP_CONVERT_OP_F2I, FP_CONVERT_OP_F2I,
      FP_CONVERT_ROUNDED_OP, FP_CONVERT_ROUNDED_OP, FP_CONVERT_ROUNDED_OP,
      FP_CONVERT_OP_I2F, FP_CONVERT_OP_I2F, FP_CONVERT_OP_I2F, FP_CONVERT_OP_I2F};
    logic [31:0] b [10] = '{32'h40200000, 32'hc0200000, 32'h40700000, 32'h40200000,
      32'h3fc00000, 32'hc0200000, 32'h01000001, 32'h01000001, 32'hffffffff,
      32'hffffffff};
    logic [4:0]  m [10] = '{5'h08, 5'h08, 5'h0a, 5'h08, 5'h00, 5'h10, 5'h00, 5'h08,
      5'h1a, 5'h02};
    logic [31:0] e [10] = '{32'h2, 32'hfffffffe, 32'h3, 32'h3, 32'h2, 32'hfffffffd,
      32'h4b800000, 32'h4b800001, 32'h4f7fffff, 32'h4f800000};
    for (int i = 0; i < 10; i++) begin
      u_core.run(o[i], 32'h0, b[i], 6'h0, m[i]);
      chk("int conv", res_data, e[i]);
    end
    $display("integer test done");
  endtask

  // Fixed-point types, fraction-bit limits, extension and fixed rounding.
  task automatic t_fix;
    spfac_op_e   o [12] = '{FP_CONVERT_OP_F2X, FP_CONVERT_OP_F2X, FP_CONVERT_OP_F2X,
      FP_CONVERT_OP_F2X, FP_CONVERT_OP_F2X, FP_CONVERT_OP_X2F, FP_CONVERT_OP_X2F,
      FP_CONVERT_OP_X2F, FP_CONVERT_OP_X2F, FP_CONVERT_OP_F2X, FP_CONVERT_OP_X2F,
      FP_CONVERT_OP_F2X};
    logic [31:0] b [12] = '{32'h3fffffff, 32'hbfffffff, 32'h3f400000, 32'h3f000000,
      32'hc0700000, 32'habcd0180, 32'h1234ffff, 32'h0000ffff, 32'h01000003,
      32'h3f800000, 32'h00000001, 32'h3f800000};
    logic [5:0]  f [12] = '{6'h08, 6'h08, 6'h10, 6'h20, 6'h01, 6'h08, 6'h00, 6'h10,
      6'h01, 6'h11, 6'h00, 6'h21};
    logic [4:0]  m [12] = '{5'h0c, 5'h14, 5'h06, 5'h02, 5'h10, 5'h1c, 5'h04, 5'h06,
      5'h18, 5'h04, 5'h00, 5'h00};
    logic [31:0] e [12] = '{32'h000001ff, 32'hfffffe01, 32'h0000c000, 32'h80000000,
      32'hfffffff9, 32'h3fc00000, 32'hbf800000, 32'h3f7fff00, 32'h4b000002,
      32'h4b000002, 32'h4b000002, 32'h4b000002};
    logic [11:0] r      = 12'he00;
    for (int i = 0; i < 12; i++) begin
      u_core.run(o[i], 32'h0, b[i], f[i], m[i]);
      chk("fix data", u_core.wr_q, e[i]);
      chk("fix status", {29'h0, u_core.got_r, u_core.got_v, u_core.got_w},
          r[i] ? 32'h4 : 32'h3);
    end
    $display("fixed test done");
  endtask

  // Long divides in two rounding modes and a short divide by zero.
  task automatic t_div;
    logic [31:0] a [4] = '{32'h40c00000, 32'h3f800000, 32'h3f800000, 32'h3f800000};
    logic [31:0] b [4] = '{32'h40000000, 32'h40400000, 32'h40400000, 32'h00000000};
    logic [4:0]  m [4] = '{5'h00, 5'h18, 5'h00, 5'h00};
    logic [31:0] e [4] = '{32'h40400000, 32'h3eaaaaaa, 32'h3eaaaaab, 32'h7f800000};
    logic [31:0] l [4] = '{32'd29, 32'd29, 32'd29, 32'd1};
    for (int i = 0; i < 4; i++) begin
      u_core.run(FP_DIVIDE_OP, a[i], b[i], 6'h0, m[i]);
      chk("div data", res_data, e[i]);
      chk("div cycles", u_core.lat, l[i]);
      chk("div busy", {31'h0, u_core.busy != 0}, {31'h0, l[i] != 1});
    end
    $display("divide test done");
  endtask

  // Main sequence: ten cycles of reset, then each scenario in turn.
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_cmp();
    t_arith();
    t_int();
    t_fix();
    t_div();
    results();
  end

  // Watchdog sized well above the roughly 180 cycles the scenarios need.
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    results();
  end
endmodule
`default_nettype wire
